// ==== design/emp_pins.sv ====
// external memory port pin sequencer
`timescale 1ns/1ps
`default_nettype none
module emp_pins #(
  parameter int unsigned ADDR_W = emp_pkg::ADDR_W,
  parameter int unsigned DATA_W = emp_pkg::DATA_W
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // access request from the core
  input wire logic i_req,
  input wire logic i_write,
  input wire logic i_dram,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [1:0] i_sram_sel,
  input wire logic i_a16_is_select,
  input wire logic [DATA_W-1:0] i_wdata,
  // configuration and state modes
  input wire logic i_narrow,
  input wire logic i_stop,
  input wire logic i_indiv_reset,
  input wire logic i_refresh_en,
  // answer to the core
  output logic o_busy,
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata,
  // memory pins
  output logic [emp_pkg::LOW_W-1:0] o_low_memory_address_lines,
  output logic o_memory_address_bit_fifteen,
  output logic o_memory_address_bit_sixteen,
  output logic o_memory_address_bit_seventeen,
  output logic o_sram_select_zero_n,
  output logic o_memory_write_strobe_n,
  output logic o_memory_read_strobe_n,
  input wire logic [DATA_W-1:0] i_memory_data_bus,
  output logic [DATA_W-1:0] o_memory_data_bus,
  output logic [DATA_W-1:0] o_memory_data_bus_oe_n
);
  typedef enum logic [1:0] {
    EMP_IDLE,
    EMP_ROW,
    EMP_XFER
  } emp_state_t;

  emp_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic dram_q, dram_d;
  logic sel16_q, sel16_d;
  logic [1:0] sel_q, sel_d;
  logic [ADDR_W-1:0] adr_q, adr_d;
  logic [DATA_W-1:0] wd_q, wd_d;
  logic [emp_pkg::LOW_W-1:0] lo_q, lo_d;
  logic p15_q, p15_d, p16_q, p16_d, p17_q, p17_d;
  logic cs0_q, cs0_d, wrs_q, wrs_d, rds_q, rds_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  logic drive, capture;

  function automatic logic sel_hit(input logic [1:0] sel, input logic [1:0] want);
    sel_hit = (sel == want);
  endfunction

  // sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    dram_d = dram_q;
    sel16_d = sel16_q;
    sel_d = sel_q;
    adr_d = adr_q;
    wd_d = wd_q;
    done_d = 1'b0;
    case (st_q)
      EMP_IDLE: begin
        // stop and individual reset hold off new accesses
        if (i_req && !i_stop && !i_indiv_reset) begin
          wr_d = i_write;
          dram_d = i_dram;
          sel16_d = i_a16_is_select;
          sel_d = i_sram_sel;
          adr_d = i_addr;
          wd_d = i_wdata;
          cnt_d = '0;
          st_d = i_dram ? EMP_ROW : EMP_XFER;
        end
      end
      EMP_ROW: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == emp_pkg::ROW_LAST) begin
          cnt_d = '0;
          st_d = EMP_XFER;
        end
      end
      default: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == emp_pkg::ACCESS_LAST) begin
          done_d = 1'b1;
          st_d = EMP_IDLE;
        end
      end
    endcase
    // registered so the busy output comes straight from a flop
    busy_d = (st_d != EMP_IDLE);
  end

  // pin values, decoded from the next state so they register in step with the sequencer state
  always_comb begin
    lo_d = lo_q;
    p15_d = p15_q;
    p16_d = p16_q;
    p17_d = p17_q;
    cs0_d = emp_pkg::PIN_IDLE;
    wrs_d = emp_pkg::PIN_IDLE;
    rds_d = emp_pkg::PIN_IDLE;
    if (i_indiv_reset) begin
      // address lines keep their state, dram strobes go active with refresh and otherwise hold
      if (i_refresh_en) begin
        p16_d = emp_pkg::PIN_ACTIVE;
        p17_d = emp_pkg::PIN_ACTIVE;
      end
    end else if (st_d == EMP_IDLE) begin
      // selects and strobes idle high; stop mode also lands here
      if (dram_q || sel_q == emp_pkg::EMP_SEL1) begin
        p17_d = emp_pkg::PIN_IDLE;
      end
      if (dram_q || (sel16_q && sel_q == emp_pkg::EMP_SEL2)) begin
        p16_d = emp_pkg::PIN_IDLE;
      end
      if (!dram_q && sel_q == emp_pkg::EMP_SEL3) begin
        p15_d = emp_pkg::PIN_IDLE;
      end
    end else if (dram_d) begin
      if (st_d == EMP_ROW) begin
        // only the address bits above the column field exist; the rest read as zero
        lo_d = '0;
        lo_d[ADDR_W-emp_pkg::ROW_LSB-1:0] = adr_d[ADDR_W-1:emp_pkg::ROW_LSB];
        p17_d = (st_q == EMP_IDLE) ? emp_pkg::PIN_IDLE : emp_pkg::PIN_ACTIVE;
        p16_d = emp_pkg::PIN_IDLE;
      end else begin
        lo_d = {{(emp_pkg::LOW_W-emp_pkg::MUX_W){1'b0}},
                adr_d[emp_pkg::MUX_W-1:0]};
        p17_d = emp_pkg::PIN_ACTIVE;
        p16_d = (st_q == EMP_ROW) ? emp_pkg::PIN_IDLE : emp_pkg::PIN_ACTIVE;
      end
      wrs_d = !(wr_d && st_d == EMP_XFER);
      rds_d = !(!wr_d && st_d == EMP_XFER);
    end else begin
      lo_d = adr_d[emp_pkg::LOW_W-1:0];
      p15_d = sel_hit(sel_d, emp_pkg::EMP_SEL3) ? emp_pkg::PIN_ACTIVE
            : adr_d[emp_pkg::BIT_A15];
      p16_d = sel16_d ? !sel_hit(sel_d, emp_pkg::EMP_SEL2)
            : adr_d[emp_pkg::BIT_A16];
      p17_d = sel_hit(sel_d, emp_pkg::EMP_SEL1) ? emp_pkg::PIN_ACTIVE
            : adr_d[emp_pkg::BIT_A17];
      cs0_d = !sel_hit(sel_d, emp_pkg::EMP_SEL0);
      wrs_d = !wr_d;
      rds_d = wr_d;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= EMP_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      dram_q <= 1'b0;
      sel16_q <= 1'b0;
      sel_q <= emp_pkg::EMP_SEL0;
      adr_q <= '0;
      wd_q <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      lo_q <= '1;
      p15_q <= emp_pkg::PIN_IDLE;
      p16_q <= emp_pkg::PIN_IDLE;
      p17_q <= emp_pkg::PIN_IDLE;
      cs0_q <= emp_pkg::PIN_IDLE;
      wrs_q <= emp_pkg::PIN_IDLE;
      rds_q <= emp_pkg::PIN_IDLE;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      dram_q <= dram_d;
      sel16_q <= sel16_d;
      sel_q <= sel_d;
      adr_q <= adr_d;
      wd_q <= wd_d;
      done_q <= done_d;
      busy_q <= busy_d;
      lo_q <= lo_d;
      p15_q <= p15_d;
      p16_q <= p16_d;
      p17_q <= p17_d;
      cs0_q <= cs0_d;
      wrs_q <= wrs_d;
      rds_q <= rds_d;
    end
  end

  // data is driven only inside a write transfer; captured on its last read cycle
  assign drive = wr_d && st_d == EMP_XFER && !i_indiv_reset;
  assign capture = !wr_q && st_q == EMP_XFER && cnt_q == emp_pkg::ACCESS_LAST;

  emp_data_lanes #(
    .DATA_W(DATA_W)
  ) u_lanes (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_drive(drive),
    .i_narrow(i_narrow),
    .i_capture(capture),
    .i_wdata(wd_d),
    .i_pin_data(i_memory_data_bus),
    .o_pin_data(o_memory_data_bus),
    .o_pin_data_oe_n(o_memory_data_bus_oe_n),
    .o_rdata(o_rdata)
  );

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_low_memory_address_lines = lo_q;
  assign o_memory_address_bit_fifteen = p15_q;
  assign o_memory_address_bit_sixteen = p16_q;
  assign o_memory_address_bit_seventeen = p17_q;
  assign o_sram_select_zero_n = cs0_q;
  assign o_memory_write_strobe_n = wrs_q;
  assign o_memory_read_strobe_n = rds_q;

  a_write_strobe_only: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !o_memory_write_strobe_n |-> $past(wr_d)) else $error("write strobe without write");
  a_read_strobe_only: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !o_memory_read_strobe_n |-> !$past(wr_d)) else $error("read strobe during write");
  a_bus_idle_released: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !$past(o_busy) && !o_busy |-> &o_memory_data_bus_oe_n) else $error("bus driven idle");
  a_narrow_upper_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_narrow && $past(i_narrow) |=> &o_memory_data_bus_oe_n[DATA_W-1:emp_pkg::NARROW_W])
    else $error("upper lanes driven in narrow mode");
  a_read_no_drive: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !o_memory_read_strobe_n |-> &o_memory_data_bus_oe_n) else $error("driving during read");
  sequence s_dram_start;
    st_q == EMP_IDLE && st_d == EMP_ROW && !i_indiv_reset;
  endsequence
  a_dram_row_first: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_dram_start |=> o_memory_address_bit_sixteen ##1 !o_memory_address_bit_seventeen
    && o_memory_address_bit_sixteen) else $error("row strobe sequence wrong");
  a_sram_sel0: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !o_sram_select_zero_n |-> $past(!dram_d && sel_d == emp_pkg::EMP_SEL0))
    else $error("select zero without sram access");
  a_indiv_refresh: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_indiv_reset && i_refresh_en |=> !o_memory_address_bit_sixteen
    && !o_memory_address_bit_seventeen && o_memory_write_strobe_n)
    else $error("individual reset strobes wrong");
  a_stop_strobes_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_stop && !o_busy && !i_indiv_reset |=> o_sram_select_zero_n && o_memory_read_strobe_n
    && o_memory_write_strobe_n) else $error("stop mode strobe low");
endmodule
`default_nettype wire

// ==== design/emp_pkg.sv ====
// constants shared by the external memory port pin logic
`default_nettype none
package emp_pkg;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned LOW_W = 15;
  localparam int unsigned MUX_W = 11;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NARROW_W = 4;
  localparam int unsigned BIT_A15 = 15;
  localparam int unsigned BIT_A16 = 16;
  localparam int unsigned BIT_A17 = 17;
  localparam int unsigned ROW_LSB = 11;
  localparam logic PIN_IDLE = 1'b1;
  localparam logic PIN_ACTIVE = 1'b0;
  localparam int unsigned ACCESS_CYCLES = 4;
  localparam logic [2:0] ACCESS_LAST = 3'h3;
  localparam int unsigned ROW_CYCLES = 2;
  localparam logic [2:0] ROW_LAST = 3'h1;
  typedef enum logic [1:0] {
    EMP_SEL0,
    EMP_SEL1,
    EMP_SEL2,
    EMP_SEL3
  } emp_sel_t;
endpackage
`default_nettype wire

// ==== design/emp_data_lanes.sv ====
// data bus lane drive control and read capture
`timescale 1ns/1ps
`default_nettype none
module emp_data_lanes #(
  parameter int unsigned DATA_W = emp_pkg::DATA_W
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_drive,
  input wire logic i_narrow,
  input wire logic i_capture,
  input wire logic [DATA_W-1:0] i_wdata,
  // pins
  input wire logic [DATA_W-1:0] i_pin_data,
  output logic [DATA_W-1:0] o_pin_data,
  output logic [DATA_W-1:0] o_pin_data_oe_n,
  output logic [DATA_W-1:0] o_rdata
);
  logic [DATA_W-1:0] data_q, data_d;
  logic [DATA_W-1:0] oe_n_q, oe_n_d;
  logic [DATA_W-1:0] rd_q, rd_d;
  always_comb begin
    data_d = i_wdata;
    oe_n_d = '1;
    rd_d = rd_q;
    for (int i = 0; i < DATA_W; i++) begin
      // upper lanes stay released in narrow mode
      if (i_drive && !(i_narrow && i >= emp_pkg::NARROW_W)) begin
        oe_n_d[i] = 1'b0;
      end
    end
    if (i_capture) begin
      rd_d = i_pin_data;
      if (i_narrow) begin
        rd_d[DATA_W-1:emp_pkg::NARROW_W] = '0;
      end
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_q <= '0;
      oe_n_q <= '1;
      rd_q <= '0;
    end else begin
      data_q <= data_d;
      oe_n_q <= oe_n_d;
      rd_q <= rd_d;
    end
  end
  assign o_pin_data = data_q;
  assign o_pin_data_oe_n = oe_n_q;
  assign o_rdata = rd_q;
endmodule
`default_nettype wire

// ==== tb/emp_mem_model.sv ====
// partner: small byte memory on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module emp_mem_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // port pins
  input wire logic [14:0] i_addr,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic [7:0] i_bus,
  input wire logic i_slow,
  // what the memory puts on the bus
  output logic [7:0] o_data
);
  logic [7:0] mem_q [16];
  logic [7:0] last_q;
  logic rd_q;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // cleared so reads of unwritten words never feed unknowns back onto the bus
      for (int i = 0; i < 16; i++) begin
        mem_q[i] <= 8'h00;
      end
      last_q <= 8'h00;
      rd_q <= 1'b0;
    end else begin
      last_q <= o_data;
      rd_q <= !i_rd_n;
      if (!i_wr_n) begin
        mem_q[i_addr[3:0]] <= i_bus;
      end
    end
  end
  // a slow part answers a cycle late; released, the bus flips every cycle
  always_comb begin
    if (!i_rd_n && (rd_q || !i_slow)) begin
      o_data = mem_q[i_addr[3:0]];
    end else begin
      o_data = ~last_q;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_external_memory_pin_interface.sv ====
// bench for the external memory port pin sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_external_memory_pin_interface;
  logic clk, rst_n, req, wr, dram, a16s, narrow, stop, ind, refr, slow;
  logic busy, done, p15, p16, p17, s0_n, wr_n, rd_n;
  logic [17:0] addr;
  logic [1:0] sel;
  logic [7:0] wdata, rdata, dout, oe_n, mdq, bus;
  logic [14:0] la;
  logic [20:0] ps [10];
  logic [15:0] ds [10];
  int fails, cmp_count, lat;
  // released lanes carry the memory side, never a stale value
  assign bus = (~oe_n & dout) | (oe_n & mdq);
  emp_pins i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_write(wr),
    .i_dram(dram), .i_addr(addr), .i_sram_sel(sel), .i_a16_is_select(a16s),
    .i_wdata(wdata), .i_narrow(narrow), .i_stop(stop), .i_indiv_reset(ind),
    .i_refresh_en(refr), .o_busy(busy), .o_done(done), .o_rdata(rdata),
    .o_low_memory_address_lines(la), .o_memory_address_bit_fifteen(p15),
    .o_memory_address_bit_sixteen(p16), .o_memory_address_bit_seventeen(p17),
    .o_sram_select_zero_n(s0_n), .o_memory_write_strobe_n(wr_n),
    .o_memory_read_strobe_n(rd_n), .i_memory_data_bus(bus),
    .o_memory_data_bus(dout), .o_memory_data_bus_oe_n(oe_n));
  emp_mem_model i_mem (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(la), .i_wr_n(wr_n),
    .i_rd_n(rd_n), .i_bus(bus), .i_slow(slow), .o_data(mdq));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one access; snapshots taken at each falling edge after the take edge
  task automatic run(input logic w, d, input logic [17:0] a, input logic [1:0] s,
                     input logic [7:0] wd);
    @(negedge clk);
    req = 1'b1;
    wr = w;
    dram = d;
    addr = a;
    sel = s;
    wdata = wd;
    lat = 0;
    do begin
      @(negedge clk);
      req = 1'b0;
      lat++;
      ps[lat] = {la, p17, p16, p15, s0_n, wr_n, rd_n};
      ds[lat] = {oe_n, dout};
    end while (done !== 1'b1 && lat < 9);
  endtask
  task automatic t_reset;
    chk({la, p17, p16, p15, s0_n, wr_n, rd_n}, 32'h1fffff);
    chk({oe_n, busy, done}, 32'h3fc);
  endtask
  task automatic t_sram;
    run(1'b1, 1'b0, 18'h2a5b3, 2'h0, 8'hc6);
    chk(lat, emp_pkg::ACCESS_CYCLES + 1);
    chk(ps[2], {15'h25b3, 6'h29});
    chk(ps[4][5:0], 6'h29);
    chk(ds[2], 16'h00c6);
    chk(ds[5][15:8], 8'hff);
    chk(ps[5][2:0], 3'h7);
    slow = 1'b1;
    run(1'b0, 1'b0, 18'h2a5b3, 2'h0, 8'h00);
    slow = 1'b0;
    chk(ps[3][5:0], 6'h2a);
    chk(ds[3][15:8], 8'hff);
    chk(rdata, 8'hc6);
  endtask
  task automatic t_sel;
    a16s = 1'b1;
    for (int s = 1; s < 4; s++) begin
      run(1'b0, 1'b0, 18'h380a5, s[1:0], 8'h00);
      chk(ps[2][5:0], {3'h7 ^ (3'h4 >> (s - 1)), 3'h6});
    end
    a16s = 1'b0;
  endtask
  task automatic t_narrow;
    narrow = 1'b1;
    run(1'b1, 1'b0, 18'h00013, 2'h0, 8'h9e);
    chk(ds[2][15:8], 8'hf0);
    chk(ds[2][3:0], 4'he);
    run(1'b0, 1'b0, 18'h00013, 2'h0, 8'h00);
    chk(ds[3][15:8], 8'hff);
    chk(rdata, 8'h0e);
    narrow = 1'b0;
  endtask
  task automatic t_dram;
    run(1'b1, 1'b1, 18'h2d36c, 2'h0, 8'h5a);
    chk(lat, emp_pkg::ACCESS_CYCLES + emp_pkg::ROW_CYCLES + 1);
    chk(ps[2][16:6], 11'h05a);
    chk(ps[2][5], 1'b0);
    chk(ps[4][16:6], 11'h36c);
    chk({ps[4][4], ps[4][1:0]}, 3'h1);
    run(1'b0, 1'b1, 18'h2d36c, 2'h0, 8'h00);
    chk({ps[4][4], ps[4][1:0]}, 3'h2);
    chk(ds[4][15:8], 8'hff);
    chk(rdata, 8'h5a);
  endtask
  task automatic t_modes;
    logic [14:0] hold;
    hold = la;
    stop = 1'b1;
    req = 1'b1;
    repeat (2) @(negedge clk);
    chk(la, hold);
    chk({s0_n, wr_n, rd_n, busy}, 4'he);
    req = 1'b0;
    stop = 1'b0;
    ind = 1'b1;
    refr = 1'b1;
    repeat (2) @(negedge clk);
    chk({la, p17, p16}, {hold, 2'h0});
    chk(oe_n, 8'hff);
    ind = 1'b0;
    refr = 1'b0;
  endtask
  initial begin
    {rst_n, req, wr, dram, a16s, narrow, stop, ind, refr, slow} = '0;
    addr = '0;
    sel = '0;
    wdata = '0;
    fails = 0;
    cmp_count = 0;
    repeat (2) @(negedge clk);
    t_reset;
    rst_n = 1'b1;
    t_sram;
    t_sel;
    t_narrow;
    t_dram;
    t_modes;
    tally_and_finish;
  end
  // the run needs well under a few hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
